/* logic/cmpc_pkg.sv */
// Shared constants, register map and carrier types for comparator control.
// Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
package cmpc_pkg;

   // Register byte addresses
   localparam logic [31:0] ADDR_ONE_CTRL = 32'h0000_0000;
   localparam logic [31:0] ADDR_TWO_CTRL = 32'h0000_0004;
   localparam logic [31:0] ADDR_TWO_EXTRA = 32'h0000_0008;

   // Field positions in a primary control register
   localparam int ENABLE_BIT = 7;
   localparam int RESULT_BIT = 6;
   localparam int DRIVE_BIT = 5;
   localparam int INVERT_BIT = 4;
   localparam int GAP_BIT = 3;
   localparam int REF_BIT = 2;
   localparam int CHAN_LSB = 0;

   // Values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] EXTRA_RESET = 8'h00;

   typedef struct packed {
      logic enable;
      logic drive;
      logic invert;
      logic ref_select;
      logic [1:0] channel;
   } cmpc_ctrl_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } cmpc_aphase_s;

   // Byte written by software to control fields; bits 6 and 3 dropped
   function automatic cmpc_ctrl_s unpack_ctrl(input logic [7:0] b);
      cmpc_ctrl_s c;
      c.enable = b[ENABLE_BIT];
      c.drive = b[DRIVE_BIT];
      c.invert = b[INVERT_BIT];
      c.ref_select = b[REF_BIT];
      c.channel = b[CHAN_LSB+1:CHAN_LSB];
      return c;
   endfunction : unpack_ctrl

   // Control fields and live result to the byte software reads
   function automatic logic [7:0] pack_ctrl(input cmpc_ctrl_s c,
                                            input logic res);
      logic [7:0] b;
      b = 8'h00;
      b[ENABLE_BIT] = c.enable;
      b[RESULT_BIT] = res;
      b[DRIVE_BIT] = c.drive;
      b[INVERT_BIT] = c.invert;
      b[GAP_BIT] = 1'b0;
      b[REF_BIT] = c.ref_select;
      b[CHAN_LSB+1:CHAN_LSB] = c.channel;
      return b;
   endfunction : pack_ctrl

endpackage : cmpc_pkg

/* logic/cmpc_top.sv */
// Control and status registers of comparator one, plus the read/write
// storage of comparator two, over an AHB-Lite slave port.
// Assumes the analog comparator output arrives asynchronously and the
// pin direction bit comes from port logic on hclk.
//
// How it works
// - Any reset loads both primary control registers and the extra one.
// - Reset values leave both comparators and the references switched off.
// - Comparator one runs only while its enable bit is set.
// - With invert set the result reads 1 when plus is below minus.
// - With invert clear the result reads 1 when plus exceeds minus.
// - The drive bit, when set, puts the result onto the output pin.
// - The pin is driven only with drive, enable and output direction.
// - The invert bit flips both the readable result and the pin level.
// - The ref bit picks internal reference or external pin for plus.
// - The two-bit channel field picks one of four minus inputs.
`timescale 1ns/10ps
module cmpc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cmp_one_raw,
   input wire logic pin_direction_bit,
   output logic cmp_one_result,
   output logic cmp_one_pin_out,
   output logic cmp_one_pin_oe,
   output logic cmp_one_power,
   output logic cmp_one_ref_select,
   output logic [1:0] cmp_one_channel_select,
   output logic cmp_two_power,
   output logic vref_power
);

   cmpc_pkg::cmpc_aphase_s aph;
   cmpc_pkg::cmpc_aphase_s next_aph;
   cmpc_pkg::cmpc_ctrl_s one;
   cmpc_pkg::cmpc_ctrl_s next_one;
   cmpc_pkg::cmpc_ctrl_s two;
   cmpc_pkg::cmpc_ctrl_s next_two;
   logic [7:0] extra;
   logic [7:0] next_extra;
   logic [31:0] next_hrdata;
   logic sync_a;
   logic sync_b;
   logic next_sync_a;
   logic next_sync_b;
   logic take;
   logic wr;
   logic one_res;
   logic next_result;
   logic next_pin_out;
   logic next_pin_oe;
   logic next_power_one;
   logic next_power_two;
   logic next_vref;
   logic next_ref_one;
   logic [1:0] next_chan_one;

   // Freezing the bus with ce keeps it from outrunning frozen state
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign take = hsel && hready && htrans[1];
   assign wr = ce && aph.valid && aph.write;

   // Disabled comparator presents a low raw level before polarity
   assign one_res = (one.enable & sync_b) ^ one.invert;

   function automatic logic [7:0] read_byte(
      input logic [31:0] a,
      input cmpc_pkg::cmpc_ctrl_s c1,
      input cmpc_pkg::cmpc_ctrl_s c2,
      input logic [7:0] ex,
      input logic res
   );
      logic [7:0] b;
      b = 8'h00;
      case (a)
         cmpc_pkg::ADDR_ONE_CTRL: b = cmpc_pkg::pack_ctrl(c1, res);
         cmpc_pkg::ADDR_TWO_CTRL: b = cmpc_pkg::pack_ctrl(c2, 1'b0);
         cmpc_pkg::ADDR_TWO_EXTRA: b = ex;
         default: b = 8'h00;
      endcase
      return b;
   endfunction : read_byte

   // Bus address phase and read data
   always_comb begin
      next_aph = aph;
      next_hrdata = hrdata;
      if (ce) begin
         next_aph.valid = take;
         next_aph.write = hwrite;
         next_aph.addr = haddr;
         // Read from next values so a write just before is seen
         if (take && !hwrite) begin
            next_hrdata = {24'h00_0000,
               read_byte(haddr, next_one, next_two, next_extra, one_res)};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph <= '0;
         hrdata <= 32'h0000_0000;
      end else begin
         aph <= next_aph;
         hrdata <= next_hrdata;
      end
   end

   // Control registers; writes to unmapped addresses are dropped
   always_comb begin
      next_one = one;
      next_two = two;
      next_extra = extra;
      if (wr) begin
         case (aph.addr)
            cmpc_pkg::ADDR_ONE_CTRL:
               next_one = cmpc_pkg::unpack_ctrl(hwdata[7:0]);
            cmpc_pkg::ADDR_TWO_CTRL:
               next_two = cmpc_pkg::unpack_ctrl(hwdata[7:0]);
            cmpc_pkg::ADDR_TWO_EXTRA:
               next_extra = hwdata[7:0];
            default: next_extra = extra;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         one <= cmpc_pkg::unpack_ctrl(cmpc_pkg::CTRL_RESET);
         two <= cmpc_pkg::unpack_ctrl(cmpc_pkg::CTRL_RESET);
         extra <= cmpc_pkg::EXTRA_RESET;
      end else begin
         one <= next_one;
         two <= next_two;
         extra <= next_extra;
      end
   end

   // Comparator level crosses in from the analog side; only the second
   // stage feeds logic, so a metastable first stage never fans out
   always_comb begin
      next_sync_a = sync_a;
      next_sync_b = sync_b;
      if (ce) begin
         next_sync_a = cmp_one_raw;
         next_sync_b = sync_a;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
      end
   end

   // Registered controls toward the analog block and the pin
   always_comb begin
      next_result = cmp_one_result;
      next_pin_out = cmp_one_pin_out;
      next_pin_oe = cmp_one_pin_oe;
      next_power_one = cmp_one_power;
      next_power_two = cmp_two_power;
      next_vref = vref_power;
      next_ref_one = cmp_one_ref_select;
      next_chan_one = cmp_one_channel_select;
      if (ce) begin
         next_result = one_res;
         next_pin_out = one_res;
         next_pin_oe = one.drive && one.enable
                       && !pin_direction_bit;
         next_power_one = one.enable;
         next_power_two = two.enable;
         next_vref = (one.enable && one.ref_select)
                     || (two.enable && two.ref_select);
         next_ref_one = one.ref_select;
         next_chan_one = one.channel;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_one_result <= 1'b0;
         cmp_one_pin_out <= 1'b0;
         cmp_one_pin_oe <= 1'b0;
         cmp_one_power <= 1'b0;
         cmp_two_power <= 1'b0;
         vref_power <= 1'b0;
         cmp_one_ref_select <= 1'b0;
         cmp_one_channel_select <= 2'b00;
      end else begin
         cmp_one_result <= next_result;
         cmp_one_pin_out <= next_pin_out;
         cmp_one_pin_oe <= next_pin_oe;
         cmp_one_power <= next_power_one;
         cmp_two_power <= next_power_two;
         vref_power <= next_vref;
         cmp_one_ref_select <= next_ref_one;
         cmp_one_channel_select <= next_chan_one;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_wr_one;
      ce && take && hwrite && haddr == cmpc_pkg::ADDR_ONE_CTRL ##1 ce;
   endsequence

   sequence s_plain_high;
      (ce && one.enable && !one.invert && cmp_one_raw)[*4];
   endsequence

   sequence s_plain_low;
      (ce && one.enable && !one.invert && !cmp_one_raw)[*4];
   endsequence

   sequence s_inv_high;
      (ce && one.enable && one.invert && cmp_one_raw)[*4];
   endsequence

   sequence s_inv_low;
      (ce && one.enable && one.invert && !cmp_one_raw)[*4];
   endsequence

   a_reset_regs: assert property (
      $rose(hresetn) |-> one == '0 && two == '0 && extra == 8'h00)
      else $error("control registers not at reset value");

   a_reset_power_off: assert property (
      $rose(hresetn) |->
         !cmp_one_power && !cmp_two_power && !vref_power)
      else $error("comparator or reference on after reset");

   a_vref_off: assert property (
      ce && !one.enable && !two.enable |=> !vref_power)
      else $error("reference powered with both comparators off");

   a_enable_write: assert property (
      s_wr_one ##1 ce |=>
         cmp_one_power == $past(hwdata[cmpc_pkg::ENABLE_BIT], 2))
      else $error("enable write not reflected in power");

   a_result_inverted: assert property (
      s_inv_high |-> !cmp_one_result)
      else $error("inverted result wrong for plus above minus");

   a_result_inv_low: assert property (
      s_inv_low |-> cmp_one_result)
      else $error("inverted result wrong for plus below minus");

   a_result_plain: assert property (
      s_plain_high |-> cmp_one_result)
      else $error("plain result wrong for plus above minus");

   a_result_plain_low: assert property (
      s_plain_low |-> !cmp_one_result)
      else $error("plain result wrong for plus below minus");

   a_drive_off: assert property (
      ce && !one.drive |=> !cmp_one_pin_oe)
      else $error("pin driven with drive bit clear");

   // A frozen enable may outlive its conditions, so only fresh values count
   a_pin_three_conds: assert property (
      cmp_one_pin_oe && $past(ce) |->
         $past(one.drive && one.enable && !pin_direction_bit))
      else $error("pin driven without all three conditions");

   a_pin_needs_dir: assert property (
      ce && pin_direction_bit |=> !cmp_one_pin_oe)
      else $error("pin driven while direction selects input");

   a_pin_polarity: assert property (
      cmp_one_pin_oe |-> cmp_one_pin_out == cmp_one_result)
      else $error("pin level differs from readable result");

   a_pin_inverted: assert property (
      s_inv_high |-> !cmp_one_pin_out)
      else $error("pin level not inverted for plus above minus");

   a_ref_write: assert property (
      s_wr_one ##1 ce |=>
         cmp_one_ref_select == $past(hwdata[cmpc_pkg::REF_BIT], 2))
      else $error("reference select not applied");

   a_chan_write: assert property (
      s_wr_one ##1 ce |=> cmp_one_channel_select == $past(hwdata[1:0], 2))
      else $error("channel select not applied");

   a_gap_bit_zero: assert property (
      hrdata[cmpc_pkg::GAP_BIT] == 1'b0 && hrdata[31:8] == 24'h00_0000)
      else $error("unimplemented read bits not zero");

   a_freeze_state: assert property (
      !ce |=> $stable(one) && $stable(hrdata) && $stable(cmp_one_pin_oe))
      else $error("state moved while clock enable low");

endmodule : cmpc_top

/* tb/testbench.sv */
// Self-checking bench for the comparator one control block.
// Assumes one AHB-Lite slave whose hreadyout feeds back as hready.
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic [7:0] ctrl;
      logic raw;
      logic dir;
      logic [7:0] exp_rd;
      logic exp_oe;
   } cmpc_row_s;
   logic hclk, hresetn, ce, hsel, hwrite, cmp_one_raw, pin_direction_bit;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, cmp_one_channel_select;
   logic [2:0] hsize;
   logic hready, hreadyout, hresp, cmp_one_result, cmp_one_pin_out;
   logic cmp_one_pin_oe, cmp_one_power, cmp_one_ref_select;
   logic cmp_two_power, vref_power;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   cmpc_row_s rows [11];
   assign hready = hreadyout;
   cmpc_top cmpc_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cmp_one_raw(cmp_one_raw),
      .pin_direction_bit(pin_direction_bit),
      .cmp_one_result(cmp_one_result), .cmp_one_pin_out(cmp_one_pin_out),
      .cmp_one_pin_oe(cmp_one_pin_oe), .cmp_one_power(cmp_one_power),
      .cmp_one_ref_select(cmp_one_ref_select),
      .cmp_one_channel_select(cmp_one_channel_select),
      .cmp_two_power(cmp_two_power), .vref_power(vref_power));
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task automatic end_sim;
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   // Five thousand cycles is far beyond the roughly one hundred fifty the tests need
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count = err_count + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Single transfer; waits on hready in both phases, data taken at end
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask : bus
   // Two sync flops plus the result register need three stable cycles
   task automatic settle;
      repeat (6) @(posedge hclk);
   endtask : settle
   task automatic chk_outs(input logic [7:0] c, input logic [7:0] r,
                           input logic oe);
      chk(cmp_one_result, r[6]);
      chk(cmp_one_pin_out, r[6]);
      chk(cmp_one_pin_oe, oe);
      chk(cmp_one_power, c[7]);
      chk(cmp_one_ref_select, c[2]);
      chk(cmp_one_channel_select, c[1:0]);
      chk(vref_power, c[7] & c[2]);
   endtask : chk_outs
   initial begin
      // Ctrl, raw, direction, expected read byte, expected pin enable
      rows = '{{8'h80, 1'b1, 1'b0, 8'hc0, 1'b0},
               {8'ha0, 1'b1, 1'b0, 8'he0, 1'b1},
               {8'ha0, 1'b1, 1'b1, 8'he0, 1'b0},
               {8'hb0, 1'b1, 1'b0, 8'hb0, 1'b1},
               {8'hb0, 1'b0, 1'b0, 8'hf0, 1'b1},
               {8'h30, 1'b1, 1'b0, 8'h70, 1'b0},
               {8'h84, 1'b0, 1'b0, 8'h84, 1'b0},
               {8'h81, 1'b1, 1'b0, 8'hc1, 1'b0},
               {8'h82, 1'b0, 1'b0, 8'h82, 1'b0},
               {8'h87, 1'b1, 1'b0, 8'hc7, 1'b0},
               {8'h00, 1'b1, 1'b0, 8'h00, 1'b0}};
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      cmp_one_raw = 1'b0;
      pin_direction_bit = 1'b1;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b1, cmpc_pkg::ADDR_ONE_CTRL, {24'h0, rows[i].ctrl}, rd);
         cmp_one_raw <= rows[i].raw;
         pin_direction_bit <= rows[i].dir;
         settle();
         chk_outs(rows[i].ctrl, rows[i].exp_rd, rows[i].exp_oe);
         bus(1'b0, cmpc_pkg::ADDR_ONE_CTRL, 32'h0, rd);
         chk(rd, {24'h0, rows[i].exp_rd});
         chk(hresp, 1'b0);
      end
      // Result and gap bits plus upper bits written must not stick
      bus(1'b1, cmpc_pkg::ADDR_ONE_CTRL, 32'hffff_ff48, rd);
      cmp_one_raw <= 1'b0;
      settle();
      bus(1'b0, cmpc_pkg::ADDR_ONE_CTRL, 32'h0, rd);
      chk(rd, 32'h0000_0000);
      // Unmapped word reads zero, write goes nowhere
      bus(1'b1, 32'h0000_0010, 32'h0000_00ff, rd);
      bus(1'b0, 32'h0000_0010, 32'h0, rd);
      chk(rd, 32'h0000_0000);
      // Load everything, then a mid-run reset must clear all of it
      bus(1'b1, cmpc_pkg::ADDR_TWO_CTRL, 32'h0000_0084, rd);
      bus(1'b1, cmpc_pkg::ADDR_TWO_EXTRA, 32'h0000_00a5, rd);
      bus(1'b1, cmpc_pkg::ADDR_ONE_CTRL, 32'h0000_00a7, rd);
      pin_direction_bit <= 1'b0;
      cmp_one_raw <= 1'b1;
      settle();
      chk(cmp_two_power, 1'b1);
      chk(vref_power, 1'b1);
      bus(1'b0, cmpc_pkg::ADDR_TWO_EXTRA, 32'h0, rd);
      chk(rd, 32'h0000_00a5);
      // Clock enable low must stall the bus and freeze state
      ce <= 1'b0;
      // A direction flip while frozen must not reach the pin enable
      pin_direction_bit <= 1'b1;
      @(posedge hclk);
      @(negedge hclk);
      chk(hreadyout, 1'b0);
      chk(cmp_one_pin_oe, 1'b1);
      @(posedge hclk);
      ce <= 1'b1;
      hresetn <= 1'b0;
      @(posedge hclk);
      @(negedge hclk);
      chk_outs(8'h00, 8'h00, 1'b0);
      chk(cmp_two_power, 1'b0);
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         if (i < 3) begin
            bus(1'b0, 32'(i * 4), 32'h0, rd);
            chk(rd, 32'h0000_0000);
         end
      end
      end_sim();
   end
endmodule : testbench
